// ---- rtl/dpd_pkg.sv ----
package dpd_pkg;
  localparam int unsigned WORD_W    = 22;
  localparam int unsigned ADDR_LSB  = 0;
  localparam int unsigned ADDR_W    = 2;
  localparam logic [1:0]  ADDR_SREF = 2'h0;
  localparam logic [1:0]  ADDR_SFB  = 2'h1;
  localparam logic [1:0]  ADDR_PREF = 2'h2;
  localparam logic [1:0]  ADDR_PFB  = 2'h3;
  localparam int unsigned REF_LSB   = 2;
  localparam int unsigned REF_W     = 15;
  localparam int unsigned SW_LSB    = 2;
  localparam int unsigned SW_W      = 5;
  localparam int unsigned PROG_LSB  = 7;
  localparam int unsigned PROG_W    = 13;
  localparam int unsigned MODSEL_BIT = 20;
  localparam int unsigned SLEEP_BIT = 21;
  localparam logic [14:0] REF_RST   = 15'h0002;
  localparam logic [12:0] PROG_RST  = 13'h0003;
  localparam logic [4:0]  SW_RST    = 5'h00;
  localparam logic        MODSEL_RST = 1'b0;
  localparam logic        SLEEP_RST = 1'b1;
  localparam logic [5:0]  MOD_8     = 6'h08;
  localparam logic [5:0]  MOD_16    = 6'h10;
  localparam logic [5:0]  MOD_32    = 6'h20;
endpackage : dpd_pkg

// ---- rtl/dpd_loop.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpd_loop #(
  parameter int unsigned REF_W  = 15,
  parameter int unsigned PROG_W = 13,
  parameter int unsigned SW_W   = 5
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              sleep,
  input  wire logic [REF_W-1:0]  ref_ratio,
  input  wire logic [PROG_W-1:0] prog_count,
  input  wire logic [SW_W-1:0]   swallow_count,
  input  wire logic              ref_tick,
  input  wire logic              presc_tick,
  output logic                   ref_div_pulse,
  output logic                   fb_div_pulse,
  output logic                   swallow_mode
);
  typedef struct packed {
    logic [REF_W-1:0]  ref_cnt;
    logic [PROG_W-1:0] prog_cnt;
    logic [SW_W-1:0]   sw_cnt;
    logic              ref_out;
    logic              fb_out;
    logic              sw_mode;
  } dpd_loop_t;

  dpd_loop_t q;
  dpd_loop_t next_q;
  logic      ref_last;
  logic      prog_last;

  assign ref_last  = (q.ref_cnt == ref_ratio - REF_W'(1));
  assign prog_last = (q.prog_cnt == prog_count - PROG_W'(1));

  always_comb begin
    next_q = q;
    next_q.ref_out = 1'b0;
    next_q.fb_out  = 1'b0;
    if (sleep) begin
      next_q = '0;
    end else begin
      if (ref_tick) begin
        next_q.ref_cnt = ref_last ? '0 : q.ref_cnt + REF_W'(1);
        next_q.ref_out = ref_last;
      end
      if (presc_tick) begin
        if (q.sw_cnt != swallow_count) begin
          next_q.sw_cnt = q.sw_cnt + SW_W'(1);
        end
        next_q.prog_cnt = prog_last ? '0 : q.prog_cnt + PROG_W'(1);
        next_q.fb_out   = prog_last;
        if (prog_last) begin
          next_q.sw_cnt = '0;
        end
      end
      next_q.sw_mode = (next_q.sw_cnt != swallow_count);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ref_div_pulse = q.ref_out;
  assign fb_div_pulse  = q.fb_out;
  assign swallow_mode  = q.sw_mode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sleep_clear;
    sleep |=> (q.ref_cnt == '0) && (q.prog_cnt == '0) && (q.sw_cnt == '0) && !fb_div_pulse;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("counters not held in sleep");

  property p_ref_wrap;
    (!sleep && ref_tick && ref_last) |=> ref_div_pulse && (q.ref_cnt == '0);
  endproperty
  a_ref_wrap: assert property (p_ref_wrap) else $error("reference divider missed wrap");

  property p_ref_quiet;
    (!sleep && !(ref_tick && ref_last)) |=> !ref_div_pulse;
  endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("spurious reference pulse");

  property p_fb_wrap;
    (!sleep && presc_tick && prog_last) |=> fb_div_pulse && (q.prog_cnt == '0);
  endproperty
  a_fb_wrap: assert property (p_fb_wrap) else $error("feedback divider missed wrap");

  property p_swallow_start;
    (!sleep && presc_tick && prog_last && swallow_count != '0 && $stable(swallow_count))
      |=> swallow_mode;
  endproperty
  a_swallow_start: assert property (p_swallow_start) else $error("no swallow at period start");
endmodule : dpd_loop
`default_nettype wire

// ---- rtl/dpd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - Address 00/10 loads reference divider latch.
// - Reference divides by binary ratio 2..32767.
// - Address 01 loads secondary feedback word.
// - Address 11 loads primary feedback word.
// - Swallow bits 6:2, program bits 19:7.
// - Bit21 sleep, bit20 modulus, bits1:0 address.
// - Programmable counter divides by 3..8191.
// - Swallow preset 0..31, zero swallows none.
// - Select bit picks prescaler modulus per band.
// - Total division P*B+A, A below P.
// - Programmable counter sets feedback period length.
// - Load strobe rising edge latches word.
// - Sleeping loop holds counters in reset.
module dpd_top #(
  parameter bit PRI_HIGH_BAND = 1'b1,
  parameter bit SEC_HIGH_BAND = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        serial_data,
  input  wire logic        word_load_strobe,
  input  wire logic        ref_osc_pin,
  input  wire logic        primary_presc_pin,
  input  wire logic        secondary_presc_pin,
  output logic [14:0]      primary_reference_ratio,
  output logic [14:0]      secondary_reference_ratio,
  output logic [12:0]      primary_program_count,
  output logic [12:0]      secondary_program_count,
  output logic [4:0]       primary_swallow_count,
  output logic [4:0]       secondary_swallow_count,
  output logic             primary_loop_sleep,
  output logic             secondary_loop_sleep,
  output logic [5:0]       primary_modulus,
  output logic [5:0]       secondary_modulus,
  output logic             primary_ref_div,
  output logic             primary_fb_div,
  output logic             primary_swallow_mode,
  output logic             secondary_ref_div,
  output logic             secondary_fb_div,
  output logic             secondary_swallow_mode,
  output logic             osc_buffer_on
);
  typedef struct packed {
    logic [21:0] word;
  } dpd_link_t;

  typedef struct packed {
    logic [2:0]  pin_meta;
    logic [2:0]  pin_sync;
    logic [2:0]  pin_prev;
    logic        le_meta;
    logic        le_sync;
    logic        le_prev;
    logic [14:0] pri_ref;
    logic [14:0] sec_ref;
    logic [12:0] pri_prog;
    logic [12:0] sec_prog;
    logic [4:0]  pri_sw;
    logic [4:0]  sec_sw;
    logic        pri_modsel;
    logic        sec_modsel;
    logic        pri_sleep;
    logic        sec_sleep;
    logic        osc_on;
  } dpd_core_t;

  dpd_link_t  lq;
  dpd_link_t  next_lq;
  dpd_core_t  q;
  dpd_core_t  next_q;
  logic       load_event;
  logic [1:0] addr;
  logic [2:0] tick;

  function automatic logic [5:0] dpd_modulus(input logic high_band, input logic sel);
    if (high_band) begin
      dpd_modulus = sel ? dpd_pkg::MOD_32 : dpd_pkg::MOD_16;
    end else begin
      dpd_modulus = sel ? dpd_pkg::MOD_16 : dpd_pkg::MOD_8;
    end
  endfunction : dpd_modulus

  // The link clock only runs while the host shifts, so nothing here may
  // depend on an edge after the last data bit.
  always_comb begin
    next_lq = lq;
    next_lq.word = {lq.word[dpd_pkg::WORD_W-2:0], serial_data};
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
    end else begin
      lq <= next_lq;
    end
  end

  // The word crosses quasi-statically: the host has stopped the link clock
  // before raising the load strobe, and the strobe passes two flops first.
  // rising strobe edge
  assign load_event = q.le_sync && !q.le_prev;
  assign addr       = lq.word[dpd_pkg::ADDR_LSB +: dpd_pkg::ADDR_W];
  assign tick       = q.pin_sync & ~q.pin_prev;

  always_comb begin
    next_q = q;
    next_q.pin_meta = {ref_osc_pin, primary_presc_pin, secondary_presc_pin};
    next_q.pin_sync = q.pin_meta;
    next_q.pin_prev = q.pin_sync;
    next_q.le_meta  = word_load_strobe;
    next_q.le_sync  = q.le_meta;
    next_q.le_prev  = q.le_sync;
    if (load_event) begin
      case (addr)
        dpd_pkg::ADDR_SREF: begin
          next_q.sec_ref = lq.word[dpd_pkg::REF_LSB +: dpd_pkg::REF_W];
        end
        dpd_pkg::ADDR_PREF: begin
          next_q.pri_ref = lq.word[dpd_pkg::REF_LSB +: dpd_pkg::REF_W];
        end
        dpd_pkg::ADDR_SFB: begin
          next_q.sec_sw     = lq.word[dpd_pkg::SW_LSB +: dpd_pkg::SW_W];
          next_q.sec_prog   = lq.word[dpd_pkg::PROG_LSB +: dpd_pkg::PROG_W];
          next_q.sec_modsel = lq.word[dpd_pkg::MODSEL_BIT];
          next_q.sec_sleep  = lq.word[dpd_pkg::SLEEP_BIT];
        end
        dpd_pkg::ADDR_PFB: begin
          next_q.pri_sw     = lq.word[dpd_pkg::SW_LSB +: dpd_pkg::SW_W];
          next_q.pri_prog   = lq.word[dpd_pkg::PROG_LSB +: dpd_pkg::PROG_W];
          next_q.pri_modsel = lq.word[dpd_pkg::MODSEL_BIT];
          next_q.pri_sleep  = lq.word[dpd_pkg::SLEEP_BIT];
        end
        default: begin
          next_q = next_q;
        end
      endcase
    end
    // The shared oscillator buffer stops only when both loops sleep.
    next_q.osc_on = !(next_q.pri_sleep && next_q.sec_sleep);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q            <= '0;
      q.pri_ref    <= dpd_pkg::REF_RST;
      q.sec_ref    <= dpd_pkg::REF_RST;
      q.pri_prog   <= dpd_pkg::PROG_RST;
      q.sec_prog   <= dpd_pkg::PROG_RST;
      q.pri_sw     <= dpd_pkg::SW_RST;
      q.sec_sw     <= dpd_pkg::SW_RST;
      q.pri_modsel <= dpd_pkg::MODSEL_RST;
      q.sec_modsel <= dpd_pkg::MODSEL_RST;
      q.pri_sleep  <= dpd_pkg::SLEEP_RST;
      q.sec_sleep  <= dpd_pkg::SLEEP_RST;
    end else begin
      q <= next_q;
    end
  end

  assign primary_reference_ratio   = q.pri_ref;
  assign secondary_reference_ratio = q.sec_ref;
  assign primary_program_count     = q.pri_prog;
  assign secondary_program_count   = q.sec_prog;
  assign primary_swallow_count     = q.pri_sw;
  assign secondary_swallow_count   = q.sec_sw;
  assign primary_loop_sleep        = q.pri_sleep;
  assign secondary_loop_sleep      = q.sec_sleep;
  assign osc_buffer_on             = q.osc_on;
  assign primary_modulus   = dpd_modulus(PRI_HIGH_BAND, q.pri_modsel);
  assign secondary_modulus = dpd_modulus(SEC_HIGH_BAND, q.sec_modsel);

  dpd_loop #(
    .REF_W  (dpd_pkg::REF_W),
    .PROG_W (dpd_pkg::PROG_W),
    .SW_W   (dpd_pkg::SW_W)
  ) u_primary (
    .clk           (clk),
    .rst_n         (rst_n),
    .sleep         (q.pri_sleep),
    .ref_ratio     (q.pri_ref),
    .prog_count    (q.pri_prog),
    .swallow_count (q.pri_sw),
    .ref_tick      (tick[2]),
    .presc_tick    (tick[1]),
    .ref_div_pulse (primary_ref_div),
    .fb_div_pulse  (primary_fb_div),
    .swallow_mode  (primary_swallow_mode)
  );

  dpd_loop #(
    .REF_W  (dpd_pkg::REF_W),
    .PROG_W (dpd_pkg::PROG_W),
    .SW_W   (dpd_pkg::SW_W)
  ) u_secondary (
    .clk           (clk),
    .rst_n         (rst_n),
    .sleep         (q.sec_sleep),
    .ref_ratio     (q.sec_ref),
    .prog_count    (q.sec_prog),
    .swallow_count (q.sec_sw),
    .ref_tick      (tick[2]),
    .presc_tick    (tick[0]),
    .ref_div_pulse (secondary_ref_div),
    .fb_div_pulse  (secondary_fb_div),
    .swallow_mode  (secondary_swallow_mode)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_load_sref;
    (load_event && addr == dpd_pkg::ADDR_SREF)
      |=> secondary_reference_ratio == $past(lq.word[16:2]);
  endproperty
  a_load_sref: assert property (p_load_sref) else $error("secondary ratio not loaded");

  property p_load_pref;
    (load_event && addr == dpd_pkg::ADDR_PREF)
      |=> primary_reference_ratio == $past(lq.word[16:2]) && $stable(secondary_reference_ratio);
  endproperty
  a_load_pref: assert property (p_load_pref) else $error("primary ratio not loaded");

  property p_load_sfb;
    (load_event && addr == dpd_pkg::ADDR_SFB)
      |=> secondary_program_count == $past(lq.word[19:7])
          && secondary_swallow_count == $past(lq.word[6:2])
          && secondary_loop_sleep == $past(lq.word[21]);
  endproperty
  a_load_sfb: assert property (p_load_sfb) else $error("secondary feedback not loaded");

  property p_load_pfb;
    (load_event && addr == dpd_pkg::ADDR_PFB)
      |=> primary_program_count == $past(lq.word[19:7])
          && primary_swallow_count == $past(lq.word[6:2])
          && primary_loop_sleep == $past(lq.word[21])
          && primary_modulus == dpd_modulus(PRI_HIGH_BAND, $past(lq.word[20]));
  endproperty
  a_load_pfb: assert property (p_load_pfb) else $error("primary feedback not loaded");

  property p_no_load_hold;
    !load_event |=> $stable(primary_program_count) && $stable(secondary_reference_ratio);
  endproperty
  a_no_load_hold: assert property (p_no_load_hold) else $error("latch changed without strobe");

  // Watch the second flop only; the first may still be settling.
  property p_strobe_latency;
    $rose(q.le_sync) |-> load_event;
  endproperty
  a_strobe_latency: assert property (p_strobe_latency) else $error("strobe edge not taken");

  property p_osc_off;
    (primary_loop_sleep && secondary_loop_sleep) |-> !osc_buffer_on;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator buffer on in full sleep");

  property p_osc_on;
    !(primary_loop_sleep && secondary_loop_sleep) |-> osc_buffer_on;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator buffer off while a loop runs");

  property p_load_sfb_mod;
    (load_event && addr == dpd_pkg::ADDR_SFB)
      |=> secondary_modulus == dpd_modulus(SEC_HIGH_BAND, $past(lq.word[20]));
  endproperty
  a_load_sfb_mod: assert property (p_load_sfb_mod) else $error("secondary modulus not loaded");

  property p_load_sref_hold;
    (load_event && addr == dpd_pkg::ADDR_SREF)
      |=> $stable(primary_reference_ratio) && $stable(secondary_program_count)
          && $stable(primary_program_count) && $stable(secondary_loop_sleep);
  endproperty
  a_load_sref_hold: assert property (p_load_sref_hold) else $error("other latch hit by ref load");

  property p_load_sfb_hold;
    (load_event && addr == dpd_pkg::ADDR_SFB)
      |=> $stable(primary_program_count) && $stable(primary_swallow_count)
          && $stable(primary_loop_sleep) && $stable(secondary_reference_ratio);
  endproperty
  a_load_sfb_hold: assert property (p_load_sfb_hold) else $error("other latch hit by sec load");

  property p_load_pfb_hold;
    (load_event && addr == dpd_pkg::ADDR_PFB)
      |=> $stable(secondary_program_count) && $stable(secondary_swallow_count)
          && $stable(secondary_loop_sleep) && $stable(primary_reference_ratio);
  endproperty
  a_load_pfb_hold: assert property (p_load_pfb_hold) else $error("other latch hit by pri load");

  property p_no_load_hold_all;
    !load_event |=> $stable(secondary_program_count) && $stable(primary_reference_ratio)
                    && $stable(primary_swallow_count) && $stable(secondary_swallow_count)
                    && $stable(primary_loop_sleep) && $stable(secondary_loop_sleep);
  endproperty
  a_no_load_hold_all: assert property (p_no_load_hold_all) else $error("latch moved, no strobe");

  // A held strobe must load once only, or a late shift would land twice.
  property p_strobe_single;
    load_event |=> !load_event;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("one strobe loaded twice");

  property p_pri_sleep_quiet;
    primary_loop_sleep |=> !primary_fb_div && !primary_ref_div && !primary_swallow_mode;
  endproperty
  a_pri_sleep_quiet: assert property (p_pri_sleep_quiet) else $error("primary loop active asleep");

  property p_sec_sleep_quiet;
    secondary_loop_sleep |=> !secondary_fb_div && !secondary_ref_div && !secondary_swallow_mode;
  endproperty
  a_sec_sleep_quiet: assert property (p_sec_sleep_quiet) else $error("secondary loop active asleep");
endmodule : dpd_top
`default_nettype wire

// ---- verification/dpd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpd_host_model (
  input  wire logic clk,
  output logic      link_clk,
  output logic      serial_data,
  output logic      word_load_strobe
);
  initial begin
    link_clk         = 1'b0;
    serial_data      = 1'b0;
    word_load_strobe = 1'b0;
  end

  // The serial clock only runs inside a frame; slow stretches each bit's setup time.
  task automatic send_word(input logic [21:0] w, input int slow);
    for (int i = 21; i >= 0; i--) begin
      serial_data = w[i];
      #(6 + slow);
      link_clk = 1'b1;
      #6;
      link_clk = 1'b0;
    end
    // The data line has no pull, so it idles at the inverse of the last bit.
    serial_data = ~w[0];
    @(posedge clk);
    word_load_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    word_load_strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : send_word
endmodule : dpd_host_model
`default_nettype wire

// ---- verification/dual_pll_divider_programming_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_pll_divider_programming_tb;
  logic        clk, rst_n, ref_pin, ppin, spin, link_clk, sdata, strobe;
  logic [14:0] pref, sref;
  logic [12:0] pprog, sprog;
  logic [4:0]  psw, ssw;
  logic [5:0]  pmod, smod;
  logic        psl, ssl, pmode, smode, prd, pfd, srd, sfd, osc_on;
  logic [31:0] seed = 32'h8b5a;
  int          bad_count, compares, cyc, lp, a, b;
  int          e_ref[2], e_prog[2], e_sw[2], e_sel[2], e_sl[2];
  int          n_rd[2], n_fd[2], n_hi[2], b_rd[2], b_fd[2], b_hi[2];

  dpd_host_model host (.clk(clk), .link_clk(link_clk), .serial_data(sdata),
    .word_load_strobe(strobe));
  dpd_top dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .serial_data(sdata),
    .word_load_strobe(strobe), .ref_osc_pin(ref_pin), .primary_presc_pin(ppin),
    .secondary_presc_pin(spin), .primary_reference_ratio(pref),
    .secondary_reference_ratio(sref), .primary_program_count(pprog),
    .secondary_program_count(sprog), .primary_swallow_count(psw),
    .secondary_swallow_count(ssw), .primary_loop_sleep(psl), .secondary_loop_sleep(ssl),
    .primary_modulus(pmod), .secondary_modulus(smod), .primary_ref_div(prd),
    .primary_fb_div(pfd), .primary_swallow_mode(pmode), .secondary_ref_div(srd),
    .secondary_fb_div(sfd), .secondary_swallow_mode(smode), .osc_buffer_on(osc_on));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_rd[0] <= n_rd[0] + int'(srd === 1'b1);
    n_rd[1] <= n_rd[1] + int'(prd === 1'b1);
    n_fd[0] <= n_fd[0] + int'(sfd === 1'b1);
    n_fd[1] <= n_fd[1] + int'(pfd === 1'b1);
    n_hi[0] <= n_hi[0] + int'(smode === 1'b1);
    n_hi[1] <= n_hi[1] + int'(pmode === 1'b1);
    if (cyc == 40000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Loop 1 is the high band part (16 or 32), loop 0 the low band part (8 or 16).
  function automatic int modv(input int l, input int sel);
    return (l == 1) ? (sel != 0 ? 32 : 16) : (sel != 0 ? 16 : 8);
  endfunction : modv

  function automatic logic [21:0] refw(input int l, input int r, input int junk);
    return {junk[4:0], r[14:0], l[0], 1'b0};
  endfunction : refw

  function automatic logic [21:0] fbw(input int l, input int sl, input int sel, input int bc,
                                      input int ac);
    return {sl[0], sel[0], bc[12:0], ac[4:0], l[0], 1'b1};
  endfunction : fbw

  task automatic cmp_val(input string nm, input logic [14:0] e, input logic [14:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp_val

  task automatic cmp_cnt(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_cnt

  task automatic check_all();
    cmp_val("sec_ref", 15'(e_ref[0]), sref);
    cmp_val("pri_ref", 15'(e_ref[1]), pref);
    cmp_val("sec_prog", 15'(e_prog[0]), {2'h0, sprog});
    cmp_val("pri_prog", 15'(e_prog[1]), {2'h0, pprog});
    cmp_val("sec_swallow", 15'(e_sw[0]), {10'h0, ssw});
    cmp_val("pri_swallow", 15'(e_sw[1]), {10'h0, psw});
    cmp_val("sec_sleep", 15'(e_sl[0]), {14'h0, ssl});
    cmp_val("pri_sleep", 15'(e_sl[1]), {14'h0, psl});
    cmp_val("sec_mod", 15'(modv(0, e_sel[0])), {9'h0, smod});
    cmp_val("pri_mod", 15'(modv(1, e_sel[1])), {9'h0, pmod});
    cmp_val("osc_on", 15'(!(e_sl[0] != 0 && e_sl[1] != 0)), {14'h0, osc_on});
  endtask : check_all

  task automatic put(input logic [21:0] w);
    int l;
    l = int'(w[1]);
    host.send_word(w, int'(w[2]) * 5);
    if (w[0]) begin
      e_sl[l] = int'(w[21]);
      e_sel[l] = int'(w[20]);
      e_prog[l] = int'(w[19:7]);
      e_sw[l] = int'(w[6:2]);
    end else begin
      e_ref[l] = int'(w[16:2]);
    end
    check_all();
  endtask : put

  // Each tick is three cycles high and three low, wider than the pin synchroniser needs.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      {spin, ppin, ref_pin} <= 3'h7;
      repeat (3) @(posedge clk);
      {spin, ppin, ref_pin} <= 3'h0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : ticks

  task automatic snap();
    b_rd = n_rd;
    b_fd = n_fd;
    b_hi = n_hi;
  endtask : snap

  task automatic cmp_pulses(input int l, input int er, input int ef);
    cmp_cnt(l ? "pri_ref_div" : "sec_ref_div", er, n_rd[l] - b_rd[l]);
    cmp_cnt(l ? "pri_fb_div" : "sec_fb_div", ef, n_fd[l] - b_fd[l]);
  endtask : cmp_pulses

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    e_ref = '{2, 2};
    e_prog = '{3, 3};
    e_sl = '{1, 1};
    rst_n = 1'b0;
    {spin, ppin, ref_pin} = 3'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_all();
    put(refw(0, 5, 31));
    put(refw(1, 5, 10));
    put(fbw(0, 0, 0, 4, 0));
    put(fbw(1, 0, 0, 4, 3));
    snap();
    ticks(4);
    cmp_pulses(0, 0, 1);
    cmp_pulses(1, 0, 1);
    put(fbw(0, 1, 0, 4, 0));
    put(fbw(1, 1, 0, 4, 3));
    snap();
    ticks(4);
    cmp_pulses(0, 0, 0);
    cmp_pulses(1, 0, 0);
    put(fbw(0, 0, 0, 4, 0));
    put(fbw(1, 0, 0, 4, 3));
    snap();
    ticks(16);
    cmp_pulses(0, 3, 4);
    cmp_pulses(1, 3, 4);
    cmp_cnt("sec_swallow_cycles", 0, n_hi[0] - b_hi[0]);
    cmp_cnt("pri_swallow_ticks", 1, int'((n_hi[1] - b_hi[1] + 3) / 6 inside {[12:15]}));
    put(refw(1, 32767, 0));
    put(refw(0, 2, 31));
    put(fbw(1, 0, 1, 8191, 31));
    put(fbw(0, 1, 1, 3, 3));
    repeat (24) begin
      seed = xs(seed);
      lp = int'(seed[8]);
      if (seed[9]) begin
        put(refw(lp, 2 + int'(seed[31:10]) % 32766, int'(seed[4:0])));
      end else begin
        b = 3 + int'(seed[31:12]) % 8189;
        a = int'(seed[7:3]) % modv(lp, int'(seed[10]));
        if (a > b) a = b;
        put(fbw(lp, int'(seed[11]), int'(seed[10]), b, a));
      end
    end
    final_report();
  end
endmodule : dual_pll_divider_programming_tb
`default_nettype wire
